/* core/sgp_consts.vh */
`ifndef SGP_CONSTS_VH
`define SGP_CONSTS_VH

// Bank registers reached through the wake-up controller bank window
`define SGP_CFG_BANK 2'h3
`define SGP_SEL_OFF 8'h13
`define SGP_CFG_OFF 8'h14

// Runtime registers, offsets from the I/O base address
`define SGP_RT_DO0 16'h0000
`define SGP_RT_DI0 16'h0001
`define SGP_RT_DO1 16'h0002
`define SGP_RT_DI1 16'h0003

// Index register fields
`define SGP_SEL_PORT 4
`define SGP_SEL_PIN_HI 2
`define SGP_SEL_WMASK 8'h17

// Pin configuration fields
`define SGP_CFG_OE 0
`define SGP_CFG_PP 1
`define SGP_CFG_PU 2
`define SGP_CFG_LOCK 3
`define SGP_CFG_LEVEL 4
`define SGP_CFG_POL 5
`define SGP_CFG_DEB 6
`define SGP_CFG_LOCK_FREE 8'hF0

// Writable field masks for each pin type
`define SGP_CFG_MASK_BIDIR 8'h7F
`define SGP_CFG_MASK_EVIN 8'h70
`define SGP_CFG_MASK_OUT 8'h0F

// Reset values for each pin type
`define SGP_CFG_RST_BIDIR 8'h44
`define SGP_CFG_RST_EVIN 8'h40
`define SGP_CFG_RST_OUT 8'h05
`define SGP_SEL_RST 8'h00
`define SGP_DO_RST 8'h00
`define SGP_PIN_IDLE 1'b1

// Debounce time and clock rate
`define SGP_DEBOUNCE_US 15000
`define SGP_CLK_MHZ 10

`endif

/* core/sgp_debounce.v */
`timescale 1ns/10ps
`default_nettype none

// Passes a level on only after it has held still for CYCLES clocks
module sgp_debounce #(
  parameter CYCLES = 150000,
  parameter CNT_W = 18
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Filter control
  input wire enable_in,
  // Level in and out
  input wire level_in,
  output wire level_out
);

`include "sgp_consts.vh"

  localparam [CNT_W-1:0] LAST = CYCLES - 1;

  reg stable_q;
  reg [CNT_W-1:0] cnt_q;

  // Any bounce back to the stable level restarts the quiet period
  always @(posedge clk_in) begin
    if (reset_in) begin
      stable_q <= `SGP_PIN_IDLE;
      cnt_q <= {CNT_W{1'b0}};
    end else if (level_in == stable_q) begin
      cnt_q <= {CNT_W{1'b0}};
    end else if (cnt_q == LAST) begin
      stable_q <= level_in;
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Filter keeps tracking while bypassed so enabling it is glitch free
  assign level_out = enable_in ? stable_q : level_in;

endmodule // sgp_debounce

`default_nettype wire

/* core/sgp_port.v */
`timescale 1ns/10ps
`default_nettype none

`include "sgp_consts.vh"

//
// Contract
// - Twelve pins; eight of them detect events.
// - Port 0 bidir then event; port 1 out then in.
// - One 8-bit configuration register per pin; plain inputs have none.
// - Config bit 0 enables the output driver.
// - Config bit 1 picks push-pull or open-drain.
// - Config bit 2 enables weak pull-up, bidir and output pins; event inputs have no pull-up.
// - Lock blocks latch and bits 0-3 until reset.
// - Enabled output drives the latch value.
// - Latch reads return stored contents only.
// - Input sample is read-only pin level; port 1 output pins read their latch.
// - Runtime registers decoded from I/O base.
// - Port enabled with the wake-up controller.
// - Inactive controller blocks runtime access only.
// - Each event pin raises its own pending bit.
// - Config bit 4 picks edge or level.
// - Config bit 5 picks direction or level.
// - Debounce needs about 15 ms without transitions.
// - Debounce delays both assertion and de-assertion.
// - Config bit 6 enables the debouncer.
// - Polarity 0 falling/low, 1 rising/high.
// - Type 0 edge by default, 1 level.
// - Index register bit 4 port, bits 2-0 pin.
module sgp_port #(
  parameter DEBOUNCE_CYCLES = `SGP_DEBOUNCE_US * `SGP_CLK_MHZ,
  parameter DEB_W = $clog2(DEBOUNCE_CYCLES + 1)
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Controller activation
  input wire active_in,
  // Runtime I/O space access
  input wire [15:0] io_base_in,
  input wire [15:0] io_addr_in,
  input wire io_wr_in,
  input wire io_rd_in,
  input wire [7:0] io_wdata_in,
  output reg [7:0] io_rdata_out,
  // Register bank access
  input wire [1:0] bank_in,
  input wire [7:0] bank_off_in,
  input wire bank_wr_in,
  input wire bank_rd_in,
  input wire [7:0] bank_wdata_in,
  output reg [7:0] bank_rdata_out,
  // Bidirectional pins, port 0 bits 5..0
  input wire [5:0] bidir_in,
  output wire [5:0] bidir_out,
  output wire [5:0] bidir_oe_n_out,
  output wire [5:0] bidir_pullup_out,
  // Event inputs, port 0 bits 7..6
  input wire [1:0] evin_in,
  // Output pins, port 1 bits 1..0
  output wire [1:0] opin_out,
  output wire [1:0] opin_oe_n_out,
  output wire [1:0] opin_pullup_out,
  // Plain inputs, port 1 bits 3..2
  input wire [1:0] plain_in,
  // Event pending indicators to wake-up status
  output wire [7:0] event_pending_out
);

  localparam NCFG = 10;

  // Synchroniser chain for the ten pin inputs
  reg [9:0] sync1_q;
  reg [9:0] sync2_q;
  reg [9:0] sync3_q;
  reg [9:0] pin_q;
  wire [9:0] pin_raw;

  // Register state
  reg [7:0] sel_q;
  reg [7:0] cfg_q [0:NCFG-1];
  reg [7:0] dout0_q;
  reg [7:0] dout1_q;

  // Event detection state
  wire [7:0] filt;
  reg [7:0] filt_prev_q;
  reg [7:0] pend;
  reg [7:0] pend_q;

  // Decode helpers
  wire [15:0] io_off;
  wire rt_ok;
  wire bank_sel_hit;
  wire bank_cfg_hit;
  wire [3:0] cfg_idx;
  wire cfg_valid;
  wire [7:0] cfg_view;
  reg [7:0] lock0;
  reg [7:0] lock1;
  reg [7:0] cfg_wmask;
  reg [7:0] cfg_next;
  wire [7:0] di0;
  wire [7:0] di1;
  integer i;

  // Pins in port order: port 0 bits 7..0, then plain inputs
  assign pin_raw = {plain_in, evin_in, bidir_in};

  // Three stages; a change counts once stages two and three agree.
  // Stage one may go metastable, so nothing but stage two reads it;
  // the price is three to four clocks of input latency
  always @(posedge clk_in) begin
    if (reset_in) begin
      sync1_q <= {10{`SGP_PIN_IDLE}};
      sync2_q <= {10{`SGP_PIN_IDLE}};
      sync3_q <= {10{`SGP_PIN_IDLE}};
      pin_q <= {10{`SGP_PIN_IDLE}};
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (sync2_q & ~(sync2_q ^ sync3_q)) |
        (pin_q & (sync2_q ^ sync3_q));
    end
  end

  // Runtime registers sit at small offsets above the I/O base
  // Addresses below the base wrap to large offsets and decode as misses
  assign io_off = io_addr_in - io_base_in;
  assign rt_ok = active_in;

  // Bank window decode for the index and configuration registers
  assign bank_sel_hit = (bank_in == `SGP_CFG_BANK) &&
    (bank_off_in == `SGP_SEL_OFF);
  assign bank_cfg_hit = (bank_in == `SGP_CFG_BANK) &&
    (bank_off_in == `SGP_CFG_OFF);

  // Index: port 0 pins map to 0..7, port 1 output pins to 8..9
  // Port 1 pins 2..7 fall outside the array; cfg_valid masks them
  assign cfg_idx = sel_q[`SGP_SEL_PORT] ?
    {1'b1, sel_q[`SGP_SEL_PIN_HI:0]} :
    {1'b0, sel_q[`SGP_SEL_PIN_HI:0]};
  // Plain input pins need no configuration and read as zero
  assign cfg_valid = !sel_q[`SGP_SEL_PORT] ||
    (sel_q[`SGP_SEL_PIN_HI:1] == 2'h0);
  assign cfg_view = cfg_valid ? cfg_q[cfg_idx] : 8'h00;

  // Lock masks over the latch bits of each port
  // Event inputs have no lock bit in their configuration, so bits 7..6 stay clear
  always @* begin
    lock0 = 8'h00;
    lock1 = 8'h00;
    for (i = 0; i < 6; i = i + 1) begin
      lock0[i] = cfg_q[i][`SGP_CFG_LOCK];
    end
    lock1[0] = cfg_q[8][`SGP_CFG_LOCK];
    lock1[1] = cfg_q[9][`SGP_CFG_LOCK];
  end

  // Next value of the selected configuration register
  // Fields that a pin type lacks are never written and read back zero
  always @* begin
    if (cfg_idx < 4'h6) begin
      cfg_wmask = `SGP_CFG_MASK_BIDIR;
    end else if (cfg_idx < 4'h8) begin
      cfg_wmask = `SGP_CFG_MASK_EVIN;
    end else begin
      cfg_wmask = `SGP_CFG_MASK_OUT;
    end
    // A locked pin keeps direction, push-pull/open-drain choice, pull-up and lock
    if (cfg_view[`SGP_CFG_LOCK]) begin
      cfg_wmask = cfg_wmask & `SGP_CFG_LOCK_FREE;
    end
    cfg_next = (cfg_view & ~cfg_wmask) | (bank_wdata_in & cfg_wmask);
    // Lock can only be set by software, never cleared
    cfg_next[`SGP_CFG_LOCK] = cfg_view[`SGP_CFG_LOCK] |
      (bank_wdata_in[`SGP_CFG_LOCK] & cfg_wmask[`SGP_CFG_LOCK]);
  end

  // Index register
  always @(posedge clk_in) begin
    if (reset_in) begin
      sel_q <= `SGP_SEL_RST;
    end else if (bank_wr_in && bank_sel_hit) begin
      sel_q <= bank_wdata_in & `SGP_SEL_WMASK;
    end
  end

  // Configuration registers; only a reset clears a lock
  // A write to an unconfigurable pin is dropped rather than aliased
  always @(posedge clk_in) begin
    if (reset_in) begin
      for (i = 0; i < 6; i = i + 1) begin
        cfg_q[i] <= `SGP_CFG_RST_BIDIR;
      end
      cfg_q[6] <= `SGP_CFG_RST_EVIN;
      cfg_q[7] <= `SGP_CFG_RST_EVIN;
      cfg_q[8] <= `SGP_CFG_RST_OUT;
      cfg_q[9] <= `SGP_CFG_RST_OUT;
    end else if (bank_wr_in && bank_cfg_hit && cfg_valid) begin
      cfg_q[cfg_idx] <= cfg_next;
    end
  end

  // Output latches; inactive controller leaves them untouched
  // Writes to the sample offsets fall through and change nothing
  always @(posedge clk_in) begin
    if (reset_in) begin
      dout0_q <= `SGP_DO_RST;
      dout1_q <= `SGP_DO_RST;
    end else if (io_wr_in && rt_ok) begin
      if (io_off == `SGP_RT_DO0) begin
        dout0_q <= (dout0_q & lock0) | (io_wdata_in & ~lock0);
      end else if (io_off == `SGP_RT_DO1) begin
        dout1_q <= (dout1_q & lock1) | (io_wdata_in & ~lock1);
      end
    end
  end

  // Input sample views; output-only pins read back their latch
  // Plain inputs skip the debouncer, as they never raise events
  assign di0 = pin_q[7:0];
  assign di1 = {4'h0, pin_q[9:8], dout1_q[1:0]};

  // Runtime read data, held until the next read
  // An inactive controller reads zero so pin levels never leak out
  always @(posedge clk_in) begin
    if (reset_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in) begin
      if (!rt_ok) begin
        io_rdata_out <= 8'h00;
      end else if (io_off == `SGP_RT_DO0) begin
        io_rdata_out <= dout0_q;
      end else if (io_off == `SGP_RT_DO1) begin
        io_rdata_out <= dout1_q;
      end else if (io_off == `SGP_RT_DI0) begin
        io_rdata_out <= di0;
      end else if (io_off == `SGP_RT_DI1) begin
        io_rdata_out <= di1;
      end else begin
        io_rdata_out <= 8'h00;
      end
    end
  end

  // Bank read data, held until the next read
  // Bank access stays open while the controller is inactive
  always @(posedge clk_in) begin
    if (reset_in) begin
      bank_rdata_out <= 8'h00;
    end else if (bank_rd_in) begin
      if (bank_sel_hit) begin
        bank_rdata_out <= sel_q;
      end else if (bank_cfg_hit) begin
        bank_rdata_out <= cfg_view;
      end else begin
        bank_rdata_out <= 8'h00;
      end
    end
  end

  // Pin drivers: open-drain drives only a low level
  // A high latch releases an open-drain pin, so the pull-up or the
  // board decides the level that the sample register sees
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_bidir
      assign bidir_out[g] = dout0_q[g];
      assign bidir_oe_n_out[g] = ~(cfg_q[g][`SGP_CFG_OE] &
        (cfg_q[g][`SGP_CFG_PP] | ~dout0_q[g]));
      assign bidir_pullup_out[g] = cfg_q[g][`SGP_CFG_PU];
    end
    for (g = 0; g < 2; g = g + 1) begin : g_opin
      assign opin_out[g] = dout1_q[g];
      assign opin_oe_n_out[g] = ~(cfg_q[8+g][`SGP_CFG_OE] &
        (cfg_q[8+g][`SGP_CFG_PP] | ~dout1_q[g]));
      assign opin_pullup_out[g] = cfg_q[8+g][`SGP_CFG_PU];
    end
  endgenerate

  // One debouncer per event-capable pin; plain inputs have none
  // Each filter holds an 18-bit counter at the default timing; that
  // area is the cost of a quiet period measured per pin
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_deb
      sgp_debounce #(
        .CYCLES(DEBOUNCE_CYCLES),
        .CNT_W(DEB_W)
      ) u_deb (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .enable_in(cfg_q[g][`SGP_CFG_DEB]),
        .level_in(pin_q[g]),
        .level_out(filt[g])
      );
    end
  endgenerate

  // Previous filtered level for edge detection
  // Reset to the idle level so no false edge follows reset
  always @(posedge clk_in) begin
    if (reset_in) begin
      filt_prev_q <= {8{`SGP_PIN_IDLE}};
    end else begin
      filt_prev_q <= filt;
    end
  end

  // Level events hold while active; edges give a one-cycle pulse
  // Changing type or polarity on the fly may raise one stray pulse
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      if (cfg_q[i][`SGP_CFG_LEVEL]) begin
        pend[i] = (filt[i] == cfg_q[i][`SGP_CFG_POL]);
      end else begin
        pend[i] = (filt[i] != filt_prev_q[i]) &&
          (filt[i] == cfg_q[i][`SGP_CFG_POL]);
      end
    end
  end

  // Pending bits leave through flip-flops, so the wake-up status logic
  // never sees a decode glitch; one clock of latency is negligible next
  // to the debounce time
  always @(posedge clk_in) begin
    if (reset_in) begin
      pend_q <= 8'h00;
    end else begin
      pend_q <= pend;
    end
  end

  // Each event pin feeds its own bit of the wake-up status logic
  assign event_pending_out = pend_q;

endmodule // sgp_port

`default_nettype wire

/* tb/sgp_board.sv */
`timescale 1ns/10ps
`default_nettype none
// Board side of the six two-way pins
module sgp_board (
  input wire logic clk_in,
  input wire logic [5:0] drv_in,
  input wire logic [5:0] oe_n_in,
  input wire logic [5:0] pu_in,
  input wire logic [5:0] ext_en_in,
  input wire logic [5:0] ext_val_in,
  output logic [5:0] pin_out
);
  logic [5:0] tog_q = 6'h00;
  // A floating line wanders, so a stale level never passes as real
  always @(posedge clk_in) tog_q <= ~tog_q;
  // Device drive first, then the board, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_out[i] = !oe_n_in[i] ? drv_in[i] : ext_en_in[i] ? ext_val_in[i] :
                   pu_in[i] ? 1'b1 : tog_q[i];
    end
  end
endmodule // sgp_board
`default_nettype wire

/* tb/sgp_port_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// Port-side checks of the standby pin block
module sgp_port_asserts (
  // Clock, reset and activation
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic active_in,
  // Register access
  input wire logic [15:0] io_base_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic [1:0] bank_in,
  input wire logic bank_wr_in,
  input wire logic bank_rd_in,
  input wire logic [7:0] bank_rdata_out,
  // Pins and events
  input wire logic [5:0] bidir_out,
  input wire logic [5:0] bidir_oe_n_out,
  input wire logic [5:0] bidir_pullup_out,
  input wire logic [1:0] opin_out,
  input wire logic [7:0] event_pending_out
);
  // Offset above the base; a clean read is an active one without a write beside it
  wire logic [15:0] off = io_addr_in - io_base_in;
  wire logic rd_ok = io_rd_in && !io_wr_in && active_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  off_hold_a:
    assert property (!active_in |=> $stable({bidir_out, opin_out}))
    else $error("latch moved while inactive");
  off_read_a:
    assert property (io_rd_in && !active_in |=> io_rdata_out == 8'h00)
    else $error("inactive read returned data");
  sample_wr_a:
    assert property (io_wr_in && off == 16'h0001 |=> $stable({bidir_out,
      opin_out})) else $error("sample write reached the latch");
  latch0_rd_a:
    assert property (rd_ok && off == 16'h0000 |=>
      io_rdata_out[5:0] == $past(bidir_out)) else $error("latch 0 read");
  latch1_rd_a:
    assert property (rd_ok && off == 16'h0002 |=>
      io_rdata_out[1:0] == $past(opin_out)) else $error("latch 1 read");
  bank_miss_a:
    assert property (bank_rd_in && bank_in != 2'h3 |=> bank_rdata_out == 8'h00)
    else $error("other bank returned data");
  pullup_hold_a:
    assert property (!bank_wr_in |=> $stable(bidir_pullup_out))
    else $error("pull-up moved without a write");
  drive_hold_a:
    assert property (!bank_wr_in && !io_wr_in |=> $stable(bidir_oe_n_out))
    else $error("driver moved without a write");
  cover property ($rose(event_pending_out[6]));
  cover property (rd_ok && off == 16'h0002);
  cover property (io_rd_in && !active_in);
endmodule // sgp_port_asserts
bind sgp_port sgp_port_asserts chk (.clk_in, .reset_in, .active_in,
  .io_base_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_rdata_out, .bank_in,
  .bank_wr_in, .bank_rd_in, .bank_rdata_out, .bidir_out, .bidir_oe_n_out,
  .bidir_pullup_out, .opin_out, .event_pending_out);
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0, reset_in = 1'b1, active_in = 1'b0;
  logic [15:0] io_base_in = 16'h0300, io_addr_in = 16'h0300;
  logic io_wr_in = 1'b0, io_rd_in = 1'b0, bank_wr_in = 1'b0, bank_rd_in = 1'b0;
  logic [7:0] io_wdata_in = 8'h00, bank_off_in = 8'h00, bank_wdata_in = 8'h00;
  logic [1:0] bank_in = 2'h3, evin_in = 2'h3, plain_in = 2'h2;
  logic [5:0] ext_en = 6'h00, ext_val = 6'h00;
  logic [7:0] idx [4] = '{8'h00, 8'h06, 8'h10, 8'h12};
  logic [7:0] rv [4] = '{8'h44, 8'h40, 8'h05, 8'h00};
  wire [7:0] io_rdata_out, bank_rdata_out, event_pending_out;
  wire [5:0] bidir_out, bidir_oe_n_out, bidir_pullup_out, pin_lvl;
  wire [1:0] opin_out, opin_oe_n_out, opin_pullup_out;
  int bad_count = 0, n_tests = 0, n;
  sgp_port #(.DEBOUNCE_CYCLES(8)) dut (.clk_in, .reset_in, .active_in,
    .io_base_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
    .io_rdata_out, .bank_in, .bank_off_in, .bank_wr_in, .bank_rd_in,
    .bank_wdata_in, .bank_rdata_out, .bidir_in(pin_lvl), .bidir_out,
    .bidir_oe_n_out, .bidir_pullup_out, .evin_in, .opin_out, .opin_oe_n_out,
    .opin_pullup_out, .plain_in, .event_pending_out);
  sgp_board board (.clk_in, .drv_in(bidir_out), .oe_n_in(bidir_oe_n_out),
    .pu_in(bidir_pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pin_out(pin_lvl));
  // 10 MHz clock
  initial forever #50 clk_in = ~clk_in;
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // Strobes last one cycle and are taken at the next edge
  task automatic bw(input logic [7:0] o, d);
    @(posedge clk_in) bank_wr_in <= 1'b1;
    bank_off_in <= o;
    bank_wdata_in <= d;
    @(posedge clk_in) bank_wr_in <= 1'b0;
    #1;
  endtask
  task automatic br(input logic [7:0] o, exp);
    @(posedge clk_in) bank_rd_in <= 1'b1;
    bank_off_in <= o;
    @(posedge clk_in) bank_rd_in <= 1'b0;
    #1 chk(bank_rdata_out, exp);
  endtask
  task automatic iw(input logic [7:0] o, d);
    @(posedge clk_in) io_wr_in <= 1'b1;
    io_addr_in <= io_base_in + {8'h00, o};
    io_wdata_in <= d;
    @(posedge clk_in) io_wr_in <= 1'b0;
    #1;
  endtask
  task automatic ir(input logic [7:0] o, exp);
    @(posedge clk_in) io_rd_in <= 1'b1;
    io_addr_in <= io_base_in + {8'h00, o};
    @(posedge clk_in) io_rd_in <= 1'b0;
    #1 chk(io_rdata_out, exp);
  endtask
  task automatic cf(input logic [7:0] i, d);
    bw(8'h13, i);
    bw(8'h14, d);
  endtask
  // Bounded wait for one pending bit, counting edges
  task automatic waitp(input int b, input logic v, output int c);
    for (c = 0; event_pending_out[b] !== v; c++) begin
      if (c == 40) begin
        bad_count++;
        $display("wrong value at %0t: pending wait ran out", $time);
        tally_and_finish;
      end
      @(posedge clk_in) #1;
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    #1 chk({opin_oe_n_out, opin_out, opin_pullup_out, 2'h0}, 8'h0C);
    @(posedge clk_in) reset_in <= 1'b0;
    active_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bw(8'h13, idx[i]);
      br(8'h14, rv[i]);
    end
    bw(8'h13, 8'hFF);
    br(8'h13, 8'h17);
    @(posedge clk_in) bank_in <= 2'h2;
    br(8'h14, 8'h00);
    @(posedge clk_in) bank_in <= 2'h3;
    iw(8'h00, 8'hA5);
    chk({2'h0, bidir_out}, 8'h25);
    iw(8'h01, 8'hFF);
    ir(8'h00, 8'hA5);
    ir(8'h04, 8'h00);
    // Pin 0 driven low by the device, pin 1 by the board
    cf(8'h00, 8'h03);
    chk({2'h0, bidir_oe_n_out}, 8'h3E);
    iw(8'h00, 8'hA4);
    @(posedge clk_in) ext_en <= 6'h02;
    repeat (6) @(posedge clk_in);
    ir(8'h01, 8'hFC);
    ir(8'h03, 8'h08);
    iw(8'h00, 8'hA5);
    cf(8'h00, 8'h05);
    chk({2'h0, bidir_oe_n_out}, 8'h3F);
    cf(8'h01, 8'h40);
    chk({2'h0, bidir_pullup_out}, 8'h3D);
    // Lock output pin 0 of port 1, then try to change it
    iw(8'h02, 8'h03);
    cf(8'h10, 8'h0D);
    bw(8'h14, 8'h00);
    br(8'h14, 8'h0D);
    iw(8'h02, 8'h00);
    ir(8'h02, 8'h01);
    @(posedge clk_in) active_in <= 1'b0;
    iw(8'h00, 8'h00);
    ir(8'h00, 8'h00);
    @(posedge clk_in) active_in <= 1'b1;
    ir(8'h00, 8'hA5);
    // Edge events on pin 6, falling then rising, debounce off
    for (int p = 0; p < 2; p++) begin
      cf(8'h06, p ? 8'h20 : 8'h00);
      @(posedge clk_in) evin_in <= p ? 2'h3 : 2'h2;
      n = 0;
      repeat (8) begin
        @(posedge clk_in) #1;
        n += (event_pending_out === 8'h40);
      end
      chk(8'(n), 8'h01);
    end
    // Level event on pin 7 without the delay of the filter
    cf(8'h07, 8'h30);
    waitp(7, 1'b1, n);
    repeat (5) @(posedge clk_in);
    #1 chk({7'h00, event_pending_out[7]}, 8'h01);
    @(posedge clk_in) evin_in <= 2'h1;
    waitp(7, 1'b0, n);
    // Filtered low-level event on pin 6, with a short bounce
    cf(8'h06, 8'h50);
    repeat (12) @(posedge clk_in);
    evin_in <= 2'h0;
    waitp(6, 1'b1, n);
    chk(8'(n > 8), 8'h01);
    @(posedge clk_in) evin_in <= 2'h1;
    repeat (3) @(posedge clk_in);
    evin_in <= 2'h0;
    n = 0;
    repeat (20) begin
      @(posedge clk_in) #1;
      n += (event_pending_out[6] !== 1'b1);
    end
    chk(8'(n), 8'h00);
    @(posedge clk_in) evin_in <= 2'h1;
    waitp(6, 1'b0, n);
    chk(8'(n > 8), 8'h01);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
